// file: design/cfs_regs.svh
// Behaviour
// - Disable pin high stops charging, high impedance
// - Disable pin high resets safety timer
// - Hot or cold pack suspends charge, freezes timers
// - Warm pack lowers regulation voltage 140 mV
// - Cool pack halves charge current target
// - Die at limit tapers charge current
// - Die trip stops converter, timers, pulses, codes
// - Restart only after die cools below trip
// - Supply below sleep level enters sleep; code stays in thermal shutdown instead
// - Supply recovery clears codes, restarts charging
// - Supply sag lowers input limit, sets flag
// - Plug-in loads supply 32 ms, then starts
// - Weak source during detection retries after 2 s
// - Weak source in operation stops converter, pulses
// - Input overvoltage stops converter, clears on recovery
// - Overvoltage ignored during detection, blocks start
// - Indicator low while charging if enabled
// - Alert pulses ignore indicator enable
// - Listed events give one 128 us pulse
// - Alert pin mirrors indicator pin
// - Regulator off in lockout, sleep, thermal shutdown
// - Error code encodings as listed
// - Supply status encodings as listed
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CFS_IDX_STATUS   3'h0
`define CFS_IDX_SUPPLY   3'h1
`define CFS_IDX_CONTROL  3'h2
`define CFS_IDX_LIMIT    3'h5
`define CFS_ADDR_STATUS  (12'h004 * `CFS_IDX_STATUS)
`define CFS_ADDR_SUPPLY  (12'h004 * `CFS_IDX_SUPPLY)
`define CFS_ADDR_CONTROL (12'h004 * `CFS_IDX_CONTROL)
`define CFS_ADDR_LIMIT   (12'h004 * `CFS_IDX_LIMIT)

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CFS_PHASE_LSB      4
`define CFS_SUPPLY_LSB     6
`define CFS_IND_EN_BIT     0
`define CFS_LIMIT_FLAG_BIT 5
`define CFS_IND_EN_RST     1'h1

`define CFS_ERR_NONE    3'h0
`define CFS_ERR_THERMAL 3'h1
`define CFS_ERR_PACK    3'h2
`define CFS_ERR_WDOG    3'h3
`define CFS_ERR_SAFETY  3'h4
`define CFS_ERR_SUPPLY  3'h5
`define CFS_ERR_BATT    3'h7

`define CFS_SUP_NORMAL 2'h0
`define CFS_SUP_OVP    2'h1
`define CFS_SUP_WEAK   2'h2
`define CFS_SUP_UVLO   2'h3

`define CFS_PH_NOSRC    3'h0
`define CFS_PH_READY    3'h1
`define CFS_PH_CHARGING 3'h3
`define CFS_PH_DONE     3'h5
`define CFS_PH_FAULT    3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFS_CLK_MHZ   100
`define CFS_PULSE_US  128
`define CFS_DETECT_MS 32
`define CFS_RETRY_S   2
`define CFS_PULSE_CYC  (`CFS_PULSE_US * `CFS_CLK_MHZ)
`define CFS_DETECT_CYC (`CFS_DETECT_MS * 1000 * `CFS_CLK_MHZ)
`define CFS_RETRY_CYC  (`CFS_RETRY_S * 1000000 * `CFS_CLK_MHZ)

`endif

// file: design/cfs_pkg.sv
package cfs_pkg;

  // ----------------------------------------------------------------
  // Comparator verdicts and external event levels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chip_disable_input;
    logic above_uvlo;
    logic above_sleep;
    logic above_weak;
    logic above_ovp;
    logic at_sag;
    logic die_at_limit;
    logic die_trip;
    logic die_recovered;
    logic pack_hot;
    logic pack_cold;
    logic pack_warm;
    logic pack_cool;
    logic safety_fault;
    logic watchdog_expired;
    logic battery_fault;
    logic charging;
    logic charge_done;
  } cfs_sense_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_HIZ, ST_DETECT, ST_RETRY, ST_RUN, ST_SLEEP, ST_OVP, ST_THERMAL
  } cfs_state_t;

  typedef struct packed {
    logic oe;
    logic out;
  } cfs_pin_t;

endpackage

// file: design/cfs_sync.sv
`timescale 1ns/1ns
module cfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule // cfs_sync

// file: design/cfs_top.sv
`timescale 1ns/1ns
`include "cfs_regs.svh"
module cfs_top #(
  parameter int unsigned PULSE_CYCLES  = `CFS_PULSE_CYC,
  parameter int unsigned DETECT_CYCLES = `CFS_DETECT_CYC,
  parameter int unsigned RETRY_CYCLES  = `CFS_RETRY_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire cfs_pkg::cfs_sense_t sense,
  output logic                    converter_enable,
  output logic                    charge_enable,
  output logic                    safety_timer_reset,
  output logic                    timers_freeze,
  output logic                    vreg_minus_140mv,
  output logic                    ichg_half,
  output logic                    ichg_taper,
  output logic                    input_limit_reduce,
  output logic                    load_sink_enable,
  output logic                    charge_cycle_start,
  output logic                    internal_regulator_output,
  output logic                    charge_indicator_out,
  output logic                    charge_indicator_oe,
  output logic                    host_alert_out,
  output logic                    host_alert_oe
);

  localparam int TW = $clog2(RETRY_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  cfs_pkg::cfs_sense_t s;
  cfs_pkg::cfs_sense_t s_q;
  logic [$bits(cfs_pkg::cfs_sense_t)-1:0] s_bits;

  cfs_sync #(.WIDTH($bits(cfs_pkg::cfs_sense_t))) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sense),
    .q       (s_bits)
  );
  assign s = cfs_pkg::cfs_sense_t'(s_bits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s;
    end
  end

  // ----------------------------------------------------------------
  // Supervisory state machine
  // ----------------------------------------------------------------
  cfs_pkg::cfs_state_t state;
  cfs_pkg::cfs_state_t next_state;
  logic [TW-1:0]       tmr;
  logic                tmr_done;
  logic                pack_fault;

  assign tmr_done   = (tmr == '0);
  assign pack_fault = s.pack_hot | s.pack_cold;

  always_comb begin
    next_state = state;
    if (!s.above_uvlo) begin
      next_state = cfs_pkg::ST_OFF;
    end else if (s.die_trip) begin
      next_state = cfs_pkg::ST_THERMAL;
    end else if (s.chip_disable_input) begin
      next_state = cfs_pkg::ST_HIZ;
    end else if (!s.above_sleep && state != cfs_pkg::ST_THERMAL) begin
      next_state = cfs_pkg::ST_SLEEP;
    end else begin
      unique case (state)
        cfs_pkg::ST_OFF:    next_state = cfs_pkg::ST_DETECT;
        cfs_pkg::ST_HIZ:    next_state = cfs_pkg::ST_DETECT;
        cfs_pkg::ST_DETECT: begin
          if (!s.above_weak) begin
            next_state = cfs_pkg::ST_RETRY;
          end else if (tmr_done) begin
            next_state = s.above_ovp ? cfs_pkg::ST_OVP : cfs_pkg::ST_RUN;
          end
        end
        cfs_pkg::ST_RETRY: begin
          if (tmr_done) begin
            next_state = cfs_pkg::ST_DETECT;
          end
        end
        cfs_pkg::ST_RUN: begin
          if (!s.above_weak) begin
            next_state = cfs_pkg::ST_RETRY;
          end else if (s.above_ovp) begin
            next_state = cfs_pkg::ST_OVP;
          end
        end
        cfs_pkg::ST_SLEEP:  next_state = cfs_pkg::ST_RUN;
        cfs_pkg::ST_OVP: begin
          if (!s.above_ovp) begin
            next_state = cfs_pkg::ST_RUN;
          end
        end
        // Wait for the die to cool.
        cfs_pkg::ST_THERMAL: begin
          if (s.die_recovered) begin
            next_state = cfs_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cfs_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // One timer serves both the load window and the retry wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr <= '0;
    end else if (next_state != state) begin
      tmr <= (next_state == cfs_pkg::ST_RETRY) ? TW'(RETRY_CYCLES - 1) :
             TW'(DETECT_CYCLES - 1);
    end else if (!tmr_done) begin
      tmr <= tmr - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable          <= 1'b0;
      charge_enable             <= 1'b0;
      timers_freeze             <= 1'b0;
      load_sink_enable          <= 1'b0;
      internal_regulator_output <= 1'b0;
      charge_cycle_start        <= 1'b0;
    end else begin
      // Pack fault suspends charge and timers.
      converter_enable <= (next_state == cfs_pkg::ST_RUN) && !pack_fault;
      charge_enable    <= (next_state == cfs_pkg::ST_RUN) && !pack_fault;
      timers_freeze    <= pack_fault || next_state == cfs_pkg::ST_THERMAL;
      load_sink_enable <= (next_state == cfs_pkg::ST_DETECT);
      internal_regulator_output <= (next_state != cfs_pkg::ST_OFF) &&
                                   (next_state != cfs_pkg::ST_SLEEP) &&
                                   (next_state != cfs_pkg::ST_THERMAL);
      charge_cycle_start <= (next_state == cfs_pkg::ST_RUN) && (state != cfs_pkg::ST_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_timer_reset <= 1'b0;
      vreg_minus_140mv   <= 1'b0;
      ichg_half          <= 1'b0;
      ichg_taper         <= 1'b0;
      input_limit_reduce <= 1'b0;
    end else begin
      safety_timer_reset <= s.chip_disable_input;
      vreg_minus_140mv   <= s.pack_warm;
      ichg_half          <= s.pack_cool;
      ichg_taper         <= s.die_at_limit;
      input_limit_reduce <= s.at_sag;
    end
  end

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  logic [2:0] error_code;
  logic [2:0] charger_phase_code;
  logic [1:0] supply_code;
  logic       held_safety;
  logic       held_wdog;
  logic       held_batt;
  logic       supply_fault_st;

  assign supply_fault_st = (state == cfs_pkg::ST_SLEEP) || (state == cfs_pkg::ST_OVP) ||
                           (state == cfs_pkg::ST_RETRY);

  // Latched faults clear on disable; a new event in that cycle still wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_safety <= 1'b0;
      held_wdog   <= 1'b0;
      held_batt   <= 1'b0;
    end else begin
      held_safety <= (s.safety_fault && !s_q.safety_fault) ||
                     (held_safety && !s.chip_disable_input);
      held_wdog   <= (s.watchdog_expired && !s_q.watchdog_expired) ||
                     (held_wdog && !s.chip_disable_input);
      held_batt   <= (s.battery_fault && !s_q.battery_fault) ||
                     (held_batt && !s.chip_disable_input);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_code         <= `CFS_ERR_NONE;
      charger_phase_code <= `CFS_PH_NOSRC;
      supply_code        <= `CFS_SUP_UVLO;
    end else begin
      if (next_state == cfs_pkg::ST_THERMAL) begin
        error_code <= `CFS_ERR_THERMAL;
      end else if (next_state == cfs_pkg::ST_SLEEP || next_state == cfs_pkg::ST_OVP ||
                   next_state == cfs_pkg::ST_RETRY) begin
        error_code <= `CFS_ERR_SUPPLY;
      end else if (pack_fault) begin
        error_code <= `CFS_ERR_PACK;
      end else if (held_batt) begin
        error_code <= `CFS_ERR_BATT;
      end else if (held_safety) begin
        error_code <= `CFS_ERR_SAFETY;
      end else if (held_wdog) begin
        error_code <= `CFS_ERR_WDOG;
      end else begin
        error_code <= `CFS_ERR_NONE;
      end
      if (next_state == cfs_pkg::ST_OFF) begin
        supply_code <= `CFS_SUP_UVLO;
      end else if (next_state == cfs_pkg::ST_OVP) begin
        supply_code <= `CFS_SUP_OVP;
      end else if (next_state == cfs_pkg::ST_RETRY) begin
        supply_code <= `CFS_SUP_WEAK;
      end else begin
        supply_code <= `CFS_SUP_NORMAL;
      end
      if (next_state == cfs_pkg::ST_THERMAL || next_state == cfs_pkg::ST_SLEEP ||
          next_state == cfs_pkg::ST_OVP || next_state == cfs_pkg::ST_RETRY) begin
        charger_phase_code <= `CFS_PH_FAULT;
      end else if (next_state == cfs_pkg::ST_RUN && s.charging) begin
        charger_phase_code <= `CFS_PH_CHARGING;
      end else if (next_state == cfs_pkg::ST_RUN && s.charge_done) begin
        charger_phase_code <= `CFS_PH_DONE;
      end else if (next_state == cfs_pkg::ST_OFF) begin
        charger_phase_code <= `CFS_PH_NOSRC;
      end else begin
        charger_phase_code <= `CFS_PH_READY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert pulses and pins
  // ----------------------------------------------------------------
  logic          alert_event;
  logic [PW-1:0] pulse_cnt;
  logic          pulse_active;
  logic          ind_enable;
  logic          drive_pin;

  function automatic logic entering(input cfs_pkg::cfs_state_t cur,
                                    input cfs_pkg::cfs_state_t nxt,
                                    input cfs_pkg::cfs_state_t tgt);
    entering = (nxt == tgt) && (cur != tgt);
  endfunction

  assign alert_event = (s.above_uvlo != s_q.above_uvlo) ||
                       (s.safety_fault && !s_q.safety_fault) ||
                       (s.watchdog_expired && !s_q.watchdog_expired) ||
                       (s.battery_fault && !s_q.battery_fault) ||
                       ((s.pack_hot || s.pack_cold) && !(s_q.pack_hot || s_q.pack_cold)) ||
                       entering(state, next_state, cfs_pkg::ST_SLEEP) ||
                       entering(state, next_state, cfs_pkg::ST_THERMAL) ||
                       entering(state, next_state, cfs_pkg::ST_RETRY) ||
                       entering(state, next_state, cfs_pkg::ST_OVP);

  assign pulse_active = (pulse_cnt != '0);

  // A new event reloads the counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (alert_event) begin
      pulse_cnt <= PW'(PULSE_CYCLES);
    end else if (pulse_active) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  assign drive_pin = alert_event || (pulse_cnt > PW'(1)) ||
                     (ind_enable && state == cfs_pkg::ST_RUN && s.charging && !pulse_active);

  // Open drain: the data is always low, only the enable moves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_indicator_oe  <= 1'b0;
      charge_indicator_out <= 1'b0;
      host_alert_oe        <= 1'b0;
      host_alert_out       <= 1'b0;
    end else begin
      charge_indicator_oe  <= drive_pin;
      charge_indicator_out <= 1'b0;
      host_alert_oe        <= drive_pin;
      host_alert_out       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic mapped;

  assign setup  = psel && !penable;
  assign mapped = (paddr == `CFS_ADDR_STATUS) || (paddr == `CFS_ADDR_SUPPLY) ||
                  (paddr == `CFS_ADDR_CONTROL) || (paddr == `CFS_ADDR_LIMIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        unique case (paddr)
          `CFS_ADDR_STATUS:  prdata <= {25'h0, charger_phase_code, 1'b0, error_code};
          `CFS_ADDR_SUPPLY:  prdata <= {24'h0, supply_code, 6'h0};
          `CFS_ADDR_CONTROL: prdata <= {31'h0, ind_enable};
          `CFS_ADDR_LIMIT:   prdata <= {26'h0, input_limit_reduce, 5'h0};
          default:           prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_enable <= `CFS_IND_EN_RST;
    end else if (psel && penable && pready && pwrite && paddr == `CFS_ADDR_CONTROL) begin
      ind_enable <= pwdata[`CFS_IND_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence fire_s;
    alert_event;
  endsequence

  sequence pulse_hold_s;
    charge_indicator_oe [*8];
  endsequence

  cd_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.above_uvlo && !s.die_trip && s.chip_disable_input |=> state == cfs_pkg::ST_HIZ
      ##1 !converter_enable)
    else $error("disable did not reach high impedance");
  timer_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.chip_disable_input |=> safety_timer_reset)
    else $error("safety timer reset missing");
  pack_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.pack_hot || s.pack_cold) |=> timers_freeze && !charge_enable)
    else $error("pack fault did not suspend");
  warm_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.pack_warm |=> vreg_minus_140mv)
    else $error("warm step missing");
  cool_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.pack_cool |=> ichg_half)
    else $error("cool half current missing");
  trip_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.above_uvlo && s.die_trip |=> state == cfs_pkg::ST_THERMAL &&
      error_code == `CFS_ERR_THERMAL && !internal_regulator_output && !converter_enable)
    else $error("thermal trip not handled");
  pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire_s |=> pulse_hold_s)
    else $error("alert pulse too short");
  sink_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == cfs_pkg::ST_DETECT |-> load_sink_enable && !converter_enable)
    else $error("detection sink wrong");
  pin_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    charge_indicator_oe == host_alert_oe)
    else $error("alert pin differs from indicator");
  sleep_reg_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == cfs_pkg::ST_SLEEP |-> !internal_regulator_output && error_code == `CFS_ERR_SUPPLY)
    else $error("sleep outputs wrong");
  ovp_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == cfs_pkg::ST_DETECT && tmr_done && s.above_ovp |=> !converter_enable)
    else $error("converter started under overvoltage");
  supply_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    supply_fault_st |-> error_code == `CFS_ERR_SUPPLY && charger_phase_code == `CFS_PH_FAULT)
    else $error("supply fault codes wrong");

endmodule // cfs_top

// file: verification/cfs_host_model.sv
`timescale 1ns/1ns
module cfs_host_model (
  input  wire logic pclk,
  input  wire logic ind_out,
  input  wire logic ind_oe,
  input  wire logic alert_out,
  input  wire logic alert_oe,
  output logic      ind_pin,
  output logic      alert_pin,
  output int        width,
  output int        pulses
);
  int run_len;
  // ----------------------------------------------------------------
  // Pins and pulse timing
  // ----------------------------------------------------------------
  // Both pins have pull-ups, so a released pin reads high.
  assign ind_pin = ind_oe ? ind_out : 1'b1;
  assign alert_pin = alert_oe ? alert_out : 1'b1;
  initial begin
    run_len = 0;
    width = 0;
    pulses = 0;
  end
  always @(posedge pclk) begin
    if (!alert_pin) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      width <= run_len;
      pulses <= pulses + 1;
      run_len <= 0;
    end
  end
endmodule // cfs_host_model

// file: verification/test_cfs_top.sv
`timescale 1ns/1ns
`include "cfs_regs.svh"
module test_cfs_top;
  localparam int PULSE = 16;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  cfs_pkg::cfs_sense_t s;
  logic                cen, chen, str, tfz, vr, ih, it, ilr, ls, ccs, ldo, io, ioe, ao, aoe;
  logic                ind_pin, alert_pin;
  int                  width, pulses, p0, errors, check_count;

  cfs_top #(.PULSE_CYCLES(PULSE), .DETECT_CYCLES(20), .RETRY_CYCLES(30)) cfs_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(s), .converter_enable(cen), .charge_enable(chen), .safety_timer_reset(str),
    .timers_freeze(tfz), .vreg_minus_140mv(vr), .ichg_half(ih), .ichg_taper(it),
    .input_limit_reduce(ilr), .load_sink_enable(ls), .charge_cycle_start(ccs),
    .internal_regulator_output(ldo), .charge_indicator_out(io),
    .charge_indicator_oe(ioe), .host_alert_out(ao), .host_alert_oe(aoe));
  cfs_host_model cfs_host_model_inst (.pclk(pclk), .ind_out(io), .ind_oe(ioe),
    .alert_out(ao), .alert_oe(aoe), .ind_pin(ind_pin), .alert_pin(alert_pin),
    .width(width), .pulses(pulses));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Several times the expected run length, so a hang ends in a failure.
  initial begin
    #20000;
    errors++;
    complete_run();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    s = '0;
    errors = 0;
    check_count = 0;
    presetn = 1'b0;
    cyc(16);
    presetn <= 1'b1;
    apb(0, `CFS_ADDR_SUPPLY, 0);
    chk("supply", rd, 32'h000000c0);
    apb(0, `CFS_ADDR_CONTROL, 0);
    chk("control", rd, 32'h00000001);
    apb(0, 12'h00c, 0);
    chk("unmapped", er, 1'b1);
    $display("test reset done");
    s.above_uvlo <= 1'b1;
    s.above_sleep <= 1'b1;
    s.above_weak <= 1'b1;
    cyc(5);
    chk("sink", {ls, cen}, 2'b10);
    cyc(30);
    chk("run", {ls, cen, ldo}, 3'b011);
    chk("width", width, PULSE);
    s.charging <= 1'b1;
    cyc(5);
    chk("ind on", {ind_pin, alert_pin}, 2'b00);
    apb(1, `CFS_ADDR_CONTROL, 0);
    cyc(3);
    chk("ind off", {ind_pin, alert_pin}, 2'b11);
    $display("test startup done");
    {s.pack_warm, s.pack_cool, s.die_at_limit, s.at_sag} <= 4'hf;
    cyc(5);
    chk("scale", {vr, ih, it, ilr}, 4'hf);
    apb(0, `CFS_ADDR_LIMIT, 0);
    chk("limit", rd, 32'h00000020);
    {s.pack_warm, s.pack_cool, s.die_at_limit, s.at_sag} <= 4'h0;
    p0 = pulses;
    s.pack_hot <= 1'b1;
    cyc(5);
    chk("hot", {cen, chen, tfz}, 3'b001);
    cyc(20);
    chk("hot pulse", pulses - p0, 1);
    chk("hot width", width, PULSE);
    s.pack_hot <= 1'b0;
    $display("test pack done");
    s.die_trip <= 1'b1;
    cyc(5);
    chk("trip", {cen, ldo, tfz}, 3'b001);
    apb(0, `CFS_ADDR_STATUS, 0);
    chk("trip code", rd[6:0], 7'h71);
    s.die_trip <= 1'b0;
    cyc(5);
    chk("still off", cen, 1'b0);
    s.die_recovered <= 1'b1;
    cyc(4);
    chk("cycle start", ccs, 1'b1);
    cyc(1);
    chk("recovered", cen, 1'b1);
    s.die_recovered <= 1'b0;
    s.above_sleep <= 1'b0;
    cyc(5);
    chk("sleep", {cen, ldo}, 2'b00);
    s.above_sleep <= 1'b1;
    cyc(5);
    apb(0, `CFS_ADDR_STATUS, 0);
    chk("wake", {cen, rd[6:0]}, 8'hb0);
    $display("test thermal sleep done");
    s.above_ovp <= 1'b1;
    cyc(5);
    apb(0, `CFS_ADDR_SUPPLY, 0);
    chk("ovp", {cen, rd[7:6]}, 3'b001);
    s.above_ovp <= 1'b0;
    cyc(5);
    apb(0, `CFS_ADDR_SUPPLY, 0);
    chk("ovp clear", {cen, rd[7:6]}, 3'b100);
    s.above_weak <= 1'b0;
    cyc(5);
    chk("weak", {cen, ls}, 2'b00);
    s.above_weak <= 1'b1;
    s.above_ovp <= 1'b1;
    cyc(35);
    chk("redetect", {cen, ls}, 2'b01);
    cyc(30);
    chk("ovp blocks", {cen, ls}, 2'b00);
    s.above_ovp <= 1'b0;
    cyc(5);
    chk("resume", cen, 1'b1);
    $display("test supply done");
    s.charging <= 1'b0;
    s.charge_done <= 1'b1;
    apb(1, `CFS_ADDR_CONTROL, 1);
    p0 = pulses;
    s.battery_fault <= 1'b1;
    cyc(25);
    chk("done pulse", pulses - p0, 1);
    chk("done width", width, PULSE);
    chk("done pins", {ind_pin, alert_pin}, 2'b11);
    apb(0, `CFS_ADDR_STATUS, 0);
    chk("done code", rd[6:0], 7'h57);
    $display("test fault done");
    s.chip_disable_input <= 1'b1;
    cyc(5);
    chk("disable", {cen, str}, 2'b01);
    apb(0, `CFS_ADDR_STATUS, 0);
    chk("disable code", rd[6:0], 7'h10);
    $display("test disable done");
    complete_run();
  end
endmodule // test_cfs_top
